// *** verilog/tlc_top.sv ***
// Temperature result formatter and critical limit comparator with AHB-Lite registers
//
// Local design decisions: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`include "tlc_params.svh"

module tlc_top
	import tlc_pkg::*;
(
	// Clock, reset, enable
	input  wire logic        mclk_i,
	input  wire logic        rst_b_i,
	input  wire logic        ce_i,
	// AHB-Lite slave
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic      [31:0] hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o,
	// Converted samples, 1/32 degree two's complement
	input  wire logic        conv_valid_i,
	input  wire logic [2:0]  conv_chan_i,
	input  wire logic [15:0] conv_temp_i,
	// Open-drain alarm pins and on-die flag
	output logic             crit_alarm_out_a_o,
	output logic             crit_alarm_out_a_oe_o,
	output logic             crit_alarm_out_b_o,
	output logic             crit_alarm_out_b_oe_o,
	output logic             crit_alarm_out_c_o,
	output logic             crit_alarm_out_c_oe_o,
	output logic             ondie_over_limit_flag_o
);
	localparam int NCH  = 5;
	localparam int NLIM = 7;

	// Registers and next values
	logic [12:0]    cfg_q, cfg_d;
	logic [4:0]     mask_q [3], mask_d [3];
	logic [7:0]     hyst_q, hyst_d;
	logic [7:0]     lim_q [NLIM], lim_d [NLIM];
	tlc_word_t      res_s_q [NCH], res_s_d [NCH];
	tlc_word_t      res_u_q [1:4], res_u_d [1:4];
	logic [2:0]     alarm_q, alarm_d;
	logic           flag_q, flag_d;
	logic           wr_pend_q, wr_pend_d;
	logic [7:0]     wr_addr_q, wr_addr_d;
	logic [31:0]    hrdata_q, hrdata_d;
	logic [31:0]    rd_val;
	logic           acc;
	logic [NLIM-1:0] over;
	logic [4:0]     stat [3];
	tlc_temp_t      temp_x, temp_s, temp_u;
	logic [NCH-1:0] smp;

	// Slot to channel: local, r1 first, r1 second, r2 first, r2 second, r3, r4
	function automatic int slot_ch(input int s);
		case (s)
			0:       return 0;
			1, 2:    return 1;
			3, 4:    return 2;
			5:       return 3;
			default: return 4;
		endcase
	endfunction : slot_ch

	// First limits of remotes one and two power up higher
	function automatic logic [7:0] lim_rst(input int s);
		return (s == 1 || s == 3) ? `TLC_LIM_HI_RST : `TLC_LIM_LO_RST;
	endfunction : lim_rst

	////////////////////////////////////////////////////////////////////////
	// Sample gating and saturation

	// Disabled channels never reach the formatter or comparators
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			smp[c] = conv_valid_i && (conv_chan_i == 3'(c)) && cfg_q[`TLC_CFG_CHEN_LSB + c];
		end
	end

	// Clamp once, so a wild sample can never roll over the word
	assign temp_x = $signed({{2{conv_temp_i[15]}}, conv_temp_i});
	assign temp_s = (temp_x > `TLC_S_MAX) ? `TLC_S_MAX :
	                (temp_x < `TLC_S_MIN) ? `TLC_S_MIN : temp_x;
	assign temp_u = (temp_x > `TLC_U_MAX) ? `TLC_U_MAX :
	                (temp_x < 18'sh00000) ? 18'sh00000 : temp_x;

	// Left-justified words; unfiltered channels lose the two finest bits
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			res_s_d[c] = res_s_q[c];
		end
		for (int c = 1; c < NCH; c++) begin
			res_u_d[c] = res_u_q[c];
		end
		if (smp[0]) begin
			res_s_d[0] = {temp_s[12:0], 3'b000} & `TLC_MASK_COARSE;
		end
		for (int c = 1; c < NCH; c++) begin
			if (smp[c]) begin
				if ((c == 1 && cfg_q[`TLC_CFG_FILT1_BIT]) || (c == 2 && cfg_q[`TLC_CFG_FILT2_BIT])) begin
					res_s_d[c] = {temp_s[12:0], 3'b000} & `TLC_MASK_FINE;
					res_u_d[c] = {temp_u[12:0], 3'b000} & `TLC_MASK_FINE;
				end else begin
					res_s_d[c] = {temp_s[12:0], 3'b000} & `TLC_MASK_COARSE;
					res_u_d[c] = {temp_u[12:0], 3'b000} & `TLC_MASK_COARSE;
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Limit slots

	// Each slot latches its own result; fault queue only on r3, r4
	generate
		for (genvar s = 0; s < NLIM; s++) begin : g_lim
			tlc_limit_cell u_cell (
				.mclk_i  (mclk_i),
				.rst_b_i (rst_b_i),
				.ce_i    (ce_i),
				.smp_i   (smp[slot_ch(s)]),
				.temp_i  (temp_x),
				.limit_i (lim_q[s]),
				.hyst_i  (hyst_q),
				.fq_en_i ((s == 5) ? cfg_q[`TLC_CFG_FQ3_BIT] : (s == 6) ? cfg_q[`TLC_CFG_FQ4_BIT] : 1'b0),
				.over_o  (over[s])
			);
		end
	endgenerate

	// Status per alarm: a sees first limits, b and c the second ones
	assign stat[0] = {over[6], over[5], over[3], over[1], over[0]};
	assign stat[1] = {over[6], over[5], over[4], over[2], over[0]};
	assign stat[2] = {over[6], over[5], over[4], over[2], over[0]};

	// Alarm is any unmasked status bit
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			alarm_d[k] = |(stat[k] & ~mask_q[k]);
		end
		flag_d = over[0];
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave, zero wait states

	assign acc = hsel_i && htrans_i[1] && hready_i;

	// Read value built from next-state copies, so a read right after a write sees it
	always_comb begin
		rd_val = 32'h0000_0000;
		case (haddr_i[7:0])
			`TLC_CFG_OFS:    rd_val = {19'h0_0000, cfg_d};
			`TLC_MASK_A_OFS: rd_val = {27'h000_0000, mask_d[0]};
			`TLC_MASK_B_OFS: rd_val = {27'h000_0000, mask_d[1]};
			`TLC_MASK_C_OFS: rd_val = {27'h000_0000, mask_d[2]};
			`TLC_HYST_OFS:   rd_val = {24'h00_0000, hyst_d};
			`TLC_STAT_A_OFS: rd_val = {27'h000_0000, stat[0]};
			`TLC_STAT_B_OFS: rd_val = {27'h000_0000, stat[1]};
			`TLC_STAT_C_OFS: rd_val = {27'h000_0000, stat[2]};
			`TLC_PINS_OFS:   rd_val = {29'h0000_0000, alarm_q};
			default: begin
				if (haddr_i[7:0] >= `TLC_LIM_BASE_OFS && haddr_i[7:0] <= `TLC_LIM_LAST_OFS
				    && haddr_i[1:0] == 2'b00) begin
					rd_val = {24'h00_0000, lim_d[3'((haddr_i[7:0] - `TLC_LIM_BASE_OFS) >> 2)]};
				end else if (haddr_i[7:0] >= `TLC_RES_S_BASE_OFS && haddr_i[7:0] <= `TLC_RES_S_LAST_OFS
				    && haddr_i[1:0] == 2'b00) begin
					rd_val = {16'h0000, res_s_q[3'((haddr_i[7:0] - `TLC_RES_S_BASE_OFS) >> 2)]};
				end else if (haddr_i[7:0] >= `TLC_RES_U_BASE_OFS && haddr_i[7:0] <= `TLC_RES_U_LAST_OFS
				    && haddr_i[1:0] == 2'b00) begin
					rd_val = {16'h0000, res_u_q[3'(((haddr_i[7:0] - `TLC_RES_U_BASE_OFS) >> 2) + 8'h01)]};
				end
			end
		endcase
	end

	// Writes land in the data phase; unmapped writes are dropped
	always_comb begin
		cfg_d     = cfg_q;
		hyst_d    = hyst_q;
		mask_d    = mask_q;
		lim_d     = lim_q;
		wr_pend_d = acc && hwrite_i;
		wr_addr_d = acc ? haddr_i[7:0] : wr_addr_q;
		if (wr_pend_q) begin
			case (wr_addr_q)
				`TLC_CFG_OFS:    cfg_d     = hwdata_i[12:0];
				`TLC_MASK_A_OFS: mask_d[0] = hwdata_i[4:0];
				`TLC_MASK_B_OFS: mask_d[1] = hwdata_i[4:0];
				`TLC_MASK_C_OFS: mask_d[2] = hwdata_i[4:0];
				`TLC_HYST_OFS:   hyst_d    = hwdata_i[7:0];
				default: begin
					if (wr_addr_q >= `TLC_LIM_BASE_OFS && wr_addr_q <= `TLC_LIM_LAST_OFS
					    && wr_addr_q[1:0] == 2'b00) begin
						lim_d[3'((wr_addr_q - `TLC_LIM_BASE_OFS) >> 2)] = hwdata_i[7:0];
					end
				end
			endcase
		end
		hrdata_d = (acc && !hwrite_i) ? rd_val : hrdata_q;
	end

	////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cfg_q     <= `TLC_CFG_RST;
			mask_q[0] <= `TLC_MASK_A_RST;
			mask_q[1] <= `TLC_MASK_B_RST;
			mask_q[2] <= `TLC_MASK_C_RST;
			hyst_q    <= `TLC_HYST_RST;
			for (int s = 0; s < NLIM; s++) begin
				lim_q[s] <= lim_rst(s);
			end
			for (int c = 0; c < NCH; c++) begin
				res_s_q[c] <= 16'h0000;
			end
			for (int c = 1; c < NCH; c++) begin
				res_u_q[c] <= 16'h0000;
			end
			alarm_q   <= 3'h0;
			flag_q    <= 1'b0;
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q  <= 32'h0000_0000;
		end else if (ce_i) begin
			cfg_q     <= cfg_d;
			mask_q    <= mask_d;
			hyst_q    <= hyst_d;
			lim_q     <= lim_d;
			res_s_q   <= res_s_d;
			res_u_q   <= res_u_d;
			alarm_q   <= alarm_d;
			flag_q    <= flag_d;
			wr_pend_q <= wr_pend_d;
			wr_addr_q <= wr_addr_d;
			hrdata_q  <= hrdata_d;
		end
	end

	// Open drain: pin level is constant low, only the enable moves
	assign crit_alarm_out_a_o      = 1'b0;
	assign crit_alarm_out_b_o      = 1'b0;
	assign crit_alarm_out_c_o      = 1'b0;
	assign crit_alarm_out_a_oe_o   = alarm_q[0];
	assign crit_alarm_out_b_oe_o   = alarm_q[1];
	assign crit_alarm_out_c_oe_o   = alarm_q[2];
	assign ondie_over_limit_flag_o = flag_q;
	assign hrdata_o                = hrdata_q;
	assign hreadyout_o             = 1'b1; // Never stretches the bus
	assign hresp_o                 = 1'b0; // Always OKAY

	////////////////////////////////////////////////////////////////////////
	// Checks

	sequence s_r3_smp;
		ce_i && smp[3];
	endsequence

	AST_LOCAL_COARSE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		res_s_q[0][4:0] == 5'h00) else $error("local word has fine bits");
	AST_R3_UNS_SAT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		s_r3_smp ##0 ($signed(conv_temp_i) > 16'sh1fff) |=> res_u_q[3] == 16'hffe0)
		else $error("unsigned top not saturated");
	AST_R3_UNS_NEG: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		s_r3_smp ##0 conv_temp_i[15] |=> res_u_q[3] == 16'h0000) else $error("negative not clamped to zero");
	AST_R1_FILT_NEG: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ce_i && smp[1] && cfg_q[`TLC_CFG_FILT1_BIT] && conv_temp_i == 16'hffff |=> res_s_q[1] == 16'hfff8)
		else $error("filtered negative step wrong");
	AST_R1_FILT_255: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ce_i && smp[1] && cfg_q[`TLC_CFG_FILT1_BIT] && conv_temp_i == 16'h1fe0 |=> res_u_q[1] == 16'hff00)
		else $error("filtered 255 degrees wrong");
	AST_ALARM_A_OR: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		ce_i |=> crit_alarm_out_a_oe_o == $past(|(stat[0] & ~mask_q[0]))) else $error("alarm a mismatch");
endmodule : tlc_top

// *** verilog/tlc_params.svh ***
// Offsets, reset values and fixed-point constants of the limit comparator
`ifndef TLC_PARAMS_SVH
`define TLC_PARAMS_SVH

// Register byte offsets, low eight address bits
`define TLC_CFG_OFS        8'h00
`define TLC_MASK_A_OFS     8'h04
`define TLC_MASK_B_OFS     8'h08
`define TLC_MASK_C_OFS     8'h0c
`define TLC_HYST_OFS       8'h10
`define TLC_LIM_BASE_OFS   8'h14
`define TLC_LIM_LAST_OFS   8'h2c
`define TLC_STAT_A_OFS     8'h30
`define TLC_STAT_B_OFS     8'h34
`define TLC_STAT_C_OFS     8'h38
`define TLC_PINS_OFS       8'h3c
`define TLC_RES_S_BASE_OFS 8'h40
`define TLC_RES_S_LAST_OFS 8'h50
`define TLC_RES_U_BASE_OFS 8'h64
`define TLC_RES_U_LAST_OFS 8'h70

// Configuration fields
`define TLC_CFG_FQ3_BIT    0
`define TLC_CFG_FQ4_BIT    1
`define TLC_CFG_FILT1_BIT  2
`define TLC_CFG_FILT2_BIT  3
`define TLC_CFG_CHEN_LSB   8

// Reset values
`define TLC_CFG_RST        13'h1f0f
`define TLC_MASK_A_RST     5'h19
`define TLC_MASK_B_RST     5'h00
`define TLC_MASK_C_RST     5'h07
`define TLC_HYST_RST       8'h0a
`define TLC_LIM_HI_RST     8'h6e
`define TLC_LIM_LO_RST     8'h55

// Fixed point: sample and word formats
`define TLC_FRAC_BITS      5
`define TLC_S_MAX          18'sh00fff
`define TLC_S_MIN          -18'sh01000
`define TLC_U_MAX          18'sh01fff
`define TLC_MASK_FINE      16'hfff8
`define TLC_MASK_COARSE    16'hffe0
`define TLC_FQ_DEPTH       3

`endif

// *** verilog/tlc_pkg.sv ***
// Types shared by the limit comparator modules
package tlc_pkg;
	typedef enum logic [1:0] {
		TLC_CMP_CLR  = 2'b01,
		TLC_CMP_OVER = 2'b10
	} tlc_cmp_state_t;
	typedef logic        [15:0] tlc_word_t;
	typedef logic signed [17:0] tlc_temp_t;
endpackage : tlc_pkg

// *** verilog/tlc_limit_cell.sv ***
// One limit slot: over-limit latch with hysteresis and optional fault queue
`timescale 1ns/1ps
`include "tlc_params.svh"

module tlc_limit_cell
	import tlc_pkg::*;
#(
	parameter int FQ_DEPTH = `TLC_FQ_DEPTH
) (
	// Clock and reset
	input  wire logic       mclk_i,
	input  wire logic       rst_b_i,
	input  wire logic       ce_i,
	// Sample and settings
	input  wire logic       smp_i,
	input  wire tlc_temp_t  temp_i,
	input  wire logic [7:0] limit_i,
	input  wire logic [7:0] hyst_i,
	input  wire logic       fq_en_i,
	// Latched result
	output logic            over_o
);
	tlc_cmp_state_t     state_q, state_d;
	logic [1:0]         cnt_q, cnt_d;
	logic signed [9:0]  lo_deg;
	tlc_temp_t          lim_fx, lo_fx;
	logic               above, below, hit;
	logic [1:0]         need;

	// Thresholds in 1/32 degree units; release point may go below zero
	assign lo_deg = $signed({2'b00, limit_i}) - $signed({2'b00, hyst_i});
	assign lim_fx = $signed({5'b0_0000, limit_i, 5'b0_0000});
	assign lo_fx  = $signed({{3{lo_deg[9]}}, lo_deg, 5'b0_0000});
	assign above  = temp_i > lim_fx;
	assign below  = temp_i < lo_fx;
	assign need   = fq_en_i ? 2'(FQ_DEPTH) : 2'h1;
	assign hit    = (state_q == TLC_CMP_CLR) ? above : below;

	// Count consecutive qualifying samples, flip when enough seen
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		if (smp_i) begin
			if (hit && (cnt_q + 2'h1 >= need)) begin
				cnt_d   = 2'h0;
				state_d = (state_q == TLC_CMP_CLR) ? TLC_CMP_OVER : TLC_CMP_CLR;
			end else if (hit) begin
				cnt_d = cnt_q + 2'h1;
			end else begin
				cnt_d = 2'h0; // A single miss restarts the queue
			end
		end
	end

	// State registers
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state_q <= TLC_CMP_CLR;
			cnt_q   <= 2'h0;
		end else if (ce_i) begin
			case (state_d)
				TLC_CMP_CLR:  state_q <= TLC_CMP_CLR;
				TLC_CMP_OVER: state_q <= TLC_CMP_OVER;
				default:      state_q <= TLC_CMP_CLR;
			endcase
			cnt_q <= cnt_d;
		end
	end

	assign over_o = (state_q == TLC_CMP_OVER);

	sequence s_hot_direct;
		ce_i && smp_i && above && !fq_en_i;
	endsequence

	AST_SET_ON_HOT: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		s_hot_direct |=> over_o) else $error("over flag not set on hot sample");
	AST_HOLD_HYST: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		over_o && !(ce_i && smp_i && below) |=> over_o) else $error("over flag dropped above release point");
	AST_FQ_THREE: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
		$rose(over_o) && $past(fq_en_i) |-> $past(cnt_q) == 2'h2) else $error("fault queue set early");
endmodule : tlc_limit_cell

// *** sim/tlc_alarm_rx.sv ***
// Alarm receiver: the far side's view of the three open-drain alarm wires
`timescale 1ns/1ps

module tlc_alarm_rx (
	// Pin drive from the block
	input  wire logic [2:0] drv_i,
	input  wire logic [2:0] oe_i,
	// Resolved wire levels
	output logic      [2:0] wire_o
);
	// External pull-ups: a released wire goes high, never holds its last level
	always_comb begin
		for (int i = 0; i < 3; i++) begin
			wire_o[i] = oe_i[i] ? drv_i[i] : 1'b1;
		end
	end
endmodule : tlc_alarm_rx

// *** sim/tlc_top_bench.sv ***
// Bench: AHB-Lite register tasks, sample injection and alarm pin checks
`timescale 1ns/1ps
`include "tlc_params.svh"

module tlc_top_bench import tlc_pkg::*;;
	// Bus, sample and pin signals
	logic        mclk;
	logic        rst_b;
	logic        hwrite;
	logic [1:0]  htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic        hready;
	logic        hresp;
	logic        cvalid;
	logic [2:0]  cchan;
	logic [15:0] ctemp;
	logic [2:0]  pdrv;
	logic [2:0]  poe;
	logic [2:0]  pwire;
	logic        flag;
	logic [31:0] rd;
	int          fail_count;
	int          num_checks;
	logic [15:0] rst_v [12] = '{16'h1f0f, 16'h19, 16'h0, 16'h7, 16'ha, 16'h55, 16'h6e, 16'h55, 16'h6e, 16'h55, 16'h55,
		16'h55};

	// Block under test; hready is the one slave's hreadyout
	tlc_top DUT (
		.mclk_i(mclk), .rst_b_i(rst_b), .ce_i(1'b1), .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
		.hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
		.hreadyout_o(hready), .hresp_o(hresp), .conv_valid_i(cvalid), .conv_chan_i(cchan), .conv_temp_i(ctemp),
		.crit_alarm_out_a_o(pdrv[0]), .crit_alarm_out_a_oe_o(poe[0]), .crit_alarm_out_b_o(pdrv[1]),
		.crit_alarm_out_b_oe_o(poe[1]), .crit_alarm_out_c_o(pdrv[2]), .crit_alarm_out_c_oe_o(poe[2]),
		.ondie_over_limit_flag_o(flag)
	);

	// Pull-up side of the alarm wires
	tlc_alarm_rx RX (.drv_i(pdrv), .oe_i(poe), .wire_o(pwire));

	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end

	////////////////////////////////////////////////////////////////////////////
	// Comparison and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic tend(input string s);
		$display("test %s done, %0d mismatches so far", s, fail_count);
	endtask : tend

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : complete_run

	////////////////////////////////////////////////////////////////////////////
	// Bus tasks; bounded wait so a stuck slave cannot hang the run
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			fail_count++;
			$display("[ERR] %0t bus wait timed out", $time);
			complete_run();
		end
	endtask : wait_rdy

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] q);
		htrans <= 2'b10;
		hwrite <= wr;
		haddr  <= {24'h0, a};
		wait_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		wait_rdy();
		q = hrdata;
	endtask : ahb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		ahb(1'b1, a, d, rd);
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0, rd);
		chk(rd, e);
	endtask : rchk

	// One sample pulse, then room for result, status and pins to land
	task automatic smp(input logic [2:0] ch, input logic [15:0] t);
		@(posedge mclk);
		cvalid <= 1'b1;
		cchan  <= ch;
		ctemp  <= t;
		@(posedge mclk);
		cvalid <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask : smp

	// Expected {flag, c, b, a}; wire must be low exactly where driven
	task automatic pchk(input logic [3:0] e);
		chk({28'h0, flag, poe}, {28'h0, e});
		chk({29'h0, pwire}, {29'h0, ~e[2:0]});
	endtask : pchk

	////////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst_b      = 1'b0;
		hwrite     = 1'b0;
		htrans     = 2'b00;
		haddr      = 32'h0;
		hwdata     = 32'h0;
		cvalid     = 1'b0;
		cchan      = 3'h0;
		ctemp      = 16'h0;
		fail_count = 0;
		num_checks = 0;
		repeat (2) @(posedge mclk);
		rst_b <= 1'b1;
		@(posedge mclk);
		// Power-up values, then read-only and unmapped places
		for (int i = 0; i < 12; i++) begin
			rchk(8'(i * 4), {16'h0, rst_v[i]});
		end
		wr(`TLC_STAT_B_OFS, 32'h1f);
		rchk(`TLC_STAT_B_OFS, 32'h0);
		rchk(8'h80, 32'h0);
		chk({31'h0, hresp}, 32'h0);
		tend("reset");
		// Local: format, strict limit, hysteresis
		smp(3'd0, 16'hffe0);
		rchk(`TLC_RES_S_BASE_OFS, 32'hff00);
		smp(3'd0, 16'd2720);
		rchk(`TLC_STAT_B_OFS, 32'h0);
		smp(3'd0, 16'd2721);
		rchk(`TLC_RES_S_BASE_OFS, 32'h5500);
		rchk(`TLC_STAT_C_OFS, 32'h1);
		pchk(4'b1010);
		smp(3'd0, 16'd2400);
		pchk(4'b1010);
		smp(3'd0, 16'd2399);
		pchk(4'b0000);
		tend("local");
		// Each output follows its own mask
		smp(3'd0, 16'd2721);
		wr(`TLC_MASK_A_OFS, 32'h0);
		wr(`TLC_MASK_B_OFS, 32'h1);
		wr(`TLC_MASK_C_OFS, 32'h1e);
		repeat (3) @(posedge mclk);
		pchk(4'b1101);
		rchk(`TLC_PINS_OFS, 32'h5);
		wr(`TLC_MASK_A_OFS, 32'h19);
		wr(`TLC_MASK_B_OFS, 32'h0);
		wr(`TLC_MASK_C_OFS, 32'h7);
		smp(3'd0, 16'h0);
		tend("masks");
		// Remote one filtered: fine step, clamps, two limits
		smp(3'd1, 16'h1);
		rchk(8'h44, 32'h8);
		rchk(`TLC_RES_U_BASE_OFS, 32'h8);
		smp(3'd1, 16'hffff);
		rchk(8'h44, 32'hfff8);
		rchk(`TLC_RES_U_BASE_OFS, 32'h0);
		smp(3'd1, 16'd8160);
		rchk(`TLC_RES_U_BASE_OFS, 32'hff00);
		rchk(8'h44, 32'h7ff8);
		rchk(`TLC_STAT_A_OFS, 32'h2);
		pchk(4'b0011);
		tend("filtered");
		// Remote one unfiltered: coarse step and clamp
		wr(`TLC_CFG_OFS, 32'h1f0b);
		smp(3'd1, 16'd9000);
		rchk(`TLC_RES_U_BASE_OFS, 32'hffe0);
		smp(3'd1, 16'd7);
		rchk(`TLC_RES_U_BASE_OFS, 32'h20);
		rchk(8'h44, 32'h20);
		pchk(4'b0000);
		wr(`TLC_CFG_OFS, 32'h1f0f);
		tend("coarse");
		// Remote two: own pair, first limit reprogrammed
		smp(3'd2, 16'd3040);
		rchk(8'h48, 32'h5f00);
		rchk(`TLC_STAT_A_OFS, 32'h0);
		rchk(`TLC_STAT_B_OFS, 32'h4);
		wr(8'h20, 32'h5a);
		smp(3'd2, 16'd3040);
		pchk(4'b0011);
		smp(3'd2, 16'h0);
		tend("remote two");
		// Remote three: three in a row to raise and to release
		for (int k = 0; k < 6; k++) begin
			smp(3'd3, (k < 3) ? 16'd2880 : 16'd0);
			rchk(`TLC_STAT_B_OFS, (k > 1 && k < 5) ? 32'h8 : 32'h0);
			if (k == 2) pchk(4'b0110);
		end
		tend("queue");
		// Remote four without queue, then a disabled local channel
		wr(`TLC_CFG_OFS, 32'h1e0d);
		smp(3'd4, 16'd2721);
		rchk(8'h50, 32'h5500);
		pchk(4'b0110);
		smp(3'd0, 16'd2721);
		rchk(`TLC_STAT_C_OFS, 32'h10);
		rchk(`TLC_RES_S_BASE_OFS, 32'h0);
		// Remote three beyond both ends; one hot sample never trips the queue
		smp(3'd3, 16'h7fff);
		rchk(8'h6c, 32'hffe0);
		rchk(8'h4c, 32'h7fe0);
		smp(3'd3, 16'h8000);
		rchk(8'h6c, 32'h0);
		rchk(8'h4c, 32'h8000);
		rchk(`TLC_STAT_C_OFS, 32'h10);
		tend("remote four");
		complete_run();
	end
endmodule : tlc_top_bench
